// File: rtl/cbt_pkg.sv
// shared constants and state types for the cpu bus timing control block
package cbt_pkg;
   // clock divider ratios and high times, counted in input clock cycles
   localparam logic [2:0] CBT_DIV_SLOW   = 3'h6;
   localparam logic [2:0] CBT_DIV_FAST   = 3'h4;
   localparam logic [2:0] CBT_HIGH_SLOW  = 3'h2;
   localparam logic [2:0] CBT_HIGH_FAST  = 3'h2;
   localparam logic [4:0] CBT_DIV_TIMER  = 5'h18;
   localparam logic [4:0] CBT_HIGH_TIMER = 5'h0c;
   // reset values
   localparam logic [7:0] CBT_BYTE_RST   = 8'h00;
   localparam logic [3:0] CBT_NIB_RST    = 4'h0;

   typedef enum logic [1:0] {
      CBT_BUS_CPU   = 2'h0,
      CBT_BUS_GRANT = 2'h1
   } cbt_bus_st_t;

   typedef struct packed {
      logic [2:0]  pcnt;
      logic        fast;
      logic        pclk;
      logic        bclk;
      logic [4:0]  tcnt;
      logic        tclk;
      logic        osc;
      logic        rst_s1;
      logic        rst_s2;
      logic        rst_bus;
      logic        rst_sys;
      logic        rst_n;
      logic        ale_q;
      logic [7:0]  lo_lat;
      logic [3:0]  hi_lat;
      logic [7:0]  mid_buf;
      cbt_bus_st_t bus_st;
      logic        grant;
      logic        addr_oe_n;
      logic        xen_n;
      logic        dir_cpu;
      logic        cpu_oe_n;
      logic        sys_oe_n;
      logic [7:0]  to_cpu;
      logic [7:0]  to_sys;
      logic        rdy_rise;
      logic        ready;
   } cbt_state_t;
endpackage : cbt_pkg

// File: rtl/cbt_bus_timing.sv
// processor side bus timing, address latch, data transceiver and ready logic
// Contract
// - divide input by 6/4 cpu, 24 timer
// - slow clock 33% high, fast 50%
// - buffered osc and cpu clocks to bus
// - low address byte latched by strobe
// - address bits 8-15 buffered only
// - bits 16-19 latched, not status
// - transceiver enabled only in data phase
// - no transceiver enable in interrupt acknowledge
// - read strobe sets transceiver direction
// - synchronise raw reset before reset outputs
// - wait line synchronised, whole clock stretches
// - ready after rising then falling edge released
// - active-low request answered by bus grant
// - address captured on strobe falling edge
// - _n names active low, others high except shared_wait_line, which is pulled low to insert waits
`timescale 1ns/1ps
`default_nettype none
module cbt_bus_timing
   import cbt_pkg::*;
(
   // clock and reset
   input  wire  logic        core_clk,
   input  wire  logic        sys_rst,
   // configuration and raw inputs
   input  wire  logic        speed_fast,
   input  wire  logic        raw_reset_in_n,
   input  wire  logic        shared_wait_line,
   input  wire  logic        ext_bus_request_n,
   // processor side
   input  wire  logic [7:0]  cpu_ad_in,
   input  wire  logic [7:0]  cpu_addr_mid,
   input  wire  logic [3:0]  cpu_addr_status,
   input  wire  logic        addr_latch_strobe,
   input  wire  logic        cpu_rd_n,
   input  wire  logic        data_phase,
   input  wire  logic        intack_cycle,
   output var   logic [7:0]  cpu_data_out,
   output var   logic        cpu_data_oe_n,
   output var   logic        cpu_ready,
   // system bus side
   input  wire  logic [7:0]  sys_data_in,
   output var   logic [7:0]  sys_data_out,
   output var   logic        sys_data_oe_n,
   output var   logic [19:0] sys_addr_out,
   output var   logic        sys_addr_oe_n,
   output var   logic        data_xcvr_enable_n,
   output var   logic        xcvr_dir_to_cpu,
   output var   logic        bus_grant_out,
   // clocks and resets
   output var   logic        processor_clock,
   output var   logic        bus_proc_clock,
   output var   logic        bus_osc_clock,
   output var   logic        timer_base_clock,
   output var   logic        bus_reset_out,
   output var   logic        sys_reset_out,
   output var   logic        reset_out_n
);
   import cbt_pkg::*;

   function automatic logic [2:0] cbt_div(input logic fast);
      cbt_div = fast ? CBT_DIV_FAST : CBT_DIV_SLOW;
   endfunction : cbt_div

   function automatic logic [2:0] cbt_high(input logic fast);
      cbt_high = fast ? CBT_HIGH_FAST : CBT_HIGH_SLOW;
   endfunction : cbt_high

   cbt_state_t s_reg;
   cbt_state_t s_next;
   logic       p_wrap;
   logic       p_fall;
   logic       t_wrap;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      // clock dividers; speed is only taken at the end of a period
      p_wrap = (s_reg.pcnt == cbt_div(s_reg.fast) - 3'h1);
      p_fall = (s_reg.pcnt == cbt_high(s_reg.fast) - 3'h1);
      s_next.pcnt = p_wrap ? 3'h0 : s_reg.pcnt + 3'h1;
      s_next.fast = p_wrap ? speed_fast : s_reg.fast;
      s_next.pclk = (s_next.pcnt < cbt_high(s_next.fast));
      s_next.bclk = s_next.pclk;
      t_wrap = (s_reg.tcnt == CBT_DIV_TIMER - 5'h1);
      s_next.tcnt = t_wrap ? 5'h00 : s_reg.tcnt + 5'h01;
      s_next.tclk = (s_next.tcnt < CBT_HIGH_TIMER);
      s_next.osc = ~s_reg.osc;

      // reset synchroniser; first stage feeds only the second
      s_next.rst_s1  = raw_reset_in_n;
      s_next.rst_s2  = s_reg.rst_s1;
      s_next.rst_bus = ~s_reg.rst_s2;
      s_next.rst_sys = ~s_reg.rst_s2;
      s_next.rst_n   = s_reg.rst_s2;

      // address latches close on the falling edge of the strobe
      s_next.ale_q = addr_latch_strobe;
      if (s_reg.ale_q && !addr_latch_strobe) begin
         s_next.lo_lat = cpu_ad_in;
         s_next.hi_lat = cpu_addr_status;
      end
      // middle bits are only buffered; one flop stage keeps outputs registered
      s_next.mid_buf = cpu_addr_mid;

      // bus arbitration; grant only taken outside a data phase
      case (s_reg.bus_st)
         CBT_BUS_CPU: begin
            if (!ext_bus_request_n && !data_phase) begin
               s_next.bus_st = CBT_BUS_GRANT;
            end
         end
         CBT_BUS_GRANT: begin
            if (ext_bus_request_n) begin
               s_next.bus_st = CBT_BUS_CPU;
            end
         end
         default: begin
            s_next.bus_st = CBT_BUS_CPU;
         end
      endcase
      s_next.grant     = (s_next.bus_st == CBT_BUS_GRANT);
      s_next.addr_oe_n = s_next.grant;

      // transceiver: data phase only, never in intack, never while granted
      s_next.xen_n    = ~(data_phase && !intack_cycle && !s_next.grant);
      s_next.dir_cpu  = ~cpu_rd_n;
      s_next.cpu_oe_n = s_next.xen_n | cpu_rd_n;
      s_next.sys_oe_n = s_next.xen_n | ~cpu_rd_n;
      s_next.to_cpu   = sys_data_in;
      s_next.to_sys   = cpu_ad_in;

      // ready: wait line seen high at a rising edge then the next falling edge
      if (p_wrap) begin
         s_next.rdy_rise = shared_wait_line;
      end
      if (p_fall) begin
         s_next.ready = s_reg.rdy_rise && shared_wait_line;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         // counters start on their last count so the first edge opens a full period
         s_reg <= '{pcnt: CBT_DIV_SLOW - 3'h1, fast: 1'b0, pclk: 1'b0, bclk: 1'b0,
                    tcnt: CBT_DIV_TIMER - 5'h01, tclk: 1'b0, osc: 1'b0, rst_s1: 1'b0,
                    rst_s2: 1'b0,
                    rst_bus: 1'b1, rst_sys: 1'b1, rst_n: 1'b0, ale_q: 1'b0,
                    lo_lat: CBT_BYTE_RST, hi_lat: CBT_NIB_RST,
                    mid_buf: CBT_BYTE_RST, bus_st: CBT_BUS_CPU, grant: 1'b0,
                    addr_oe_n: 1'b0, xen_n: 1'b1, dir_cpu: 1'b0,
                    cpu_oe_n: 1'b1, sys_oe_n: 1'b1, to_cpu: CBT_BYTE_RST,
                    to_sys: CBT_BYTE_RST, rdy_rise: 1'b0, ready: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      cpu_data_out       = s_reg.to_cpu;
      cpu_data_oe_n      = s_reg.cpu_oe_n;
      cpu_ready          = s_reg.ready;
      sys_data_out       = s_reg.to_sys;
      sys_data_oe_n      = s_reg.sys_oe_n;
      sys_addr_out       = {s_reg.hi_lat, s_reg.mid_buf, s_reg.lo_lat};
      sys_addr_oe_n      = s_reg.addr_oe_n;
      data_xcvr_enable_n = s_reg.xen_n;
      xcvr_dir_to_cpu    = s_reg.dir_cpu;
      bus_grant_out      = s_reg.grant;
      processor_clock    = s_reg.pclk;
      bus_proc_clock     = s_reg.bclk;
      bus_osc_clock      = s_reg.osc;
      timer_base_clock   = s_reg.tclk;
      bus_reset_out      = s_reg.rst_bus;
      sys_reset_out      = s_reg.rst_sys;
      reset_out_n        = s_reg.rst_n;
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_slow_clock_shape: assert property ((!s_reg.fast && s_reg.pcnt == 3'h0)
      |-> s_reg.pclk ##1 s_reg.pclk ##1 !s_reg.pclk ##1 !s_reg.pclk ##1 !s_reg.pclk
          ##1 !s_reg.pclk) else $error("slow clock not 2 high 4 low");
   a_fast_clock_shape: assert property ((s_reg.fast && s_reg.pcnt == 3'h0)
      |-> s_reg.pclk ##1 s_reg.pclk ##1 !s_reg.pclk ##1 !s_reg.pclk)
      else $error("fast clock not 2 high 2 low");
   a_speed_at_bound: assert property ($changed(s_reg.fast)
      |-> s_reg.pcnt == 3'h0) else $error("speed changed mid period");
   a_timer_period: assert property ($rose(s_reg.tclk)
      |-> s_reg.tclk [*8] ##5 !s_reg.tclk [*8]) else $error("timer clock shape wrong");
   a_addr_latch_hold: assert property ((s_reg.ale_q && !addr_latch_strobe)
      |=> sys_addr_out[7:0] == $past(cpu_ad_in)) else $error("low address not latched");
   a_status_blocked: assert property (!(s_reg.ale_q && !addr_latch_strobe)
      |=> $stable(sys_addr_out[19:16])) else $error("status leaked onto bus");
   a_xcvr_gating: assert property ((!data_phase || intack_cycle)
      |=> data_xcvr_enable_n) else $error("transceiver on outside data phase");
   a_grant_floats: assert property (bus_grant_out
      |-> sys_addr_oe_n && data_xcvr_enable_n) else $error("bus driven under grant");
   a_grant_answer: assert property ((!ext_bus_request_n && !data_phase && !bus_grant_out)
      |=> bus_grant_out) else $error("request not granted");
   a_ready_needs_high: assert property ($rose(cpu_ready)
      |-> $past(shared_wait_line)) else $error("ready without released wait");
   a_reset_sync: assert property ($fell(raw_reset_in_n)
      |-> ##3 bus_reset_out && !reset_out_n) else $error("reset not synchronised");

   c_speed_switch: cover property ($changed(s_reg.fast));
   c_wait_stretch: cover property (!shared_wait_line ##1 shared_wait_line [*8] ##1 cpu_ready);
   c_grant_cycle: cover property ($rose(bus_grant_out) ##[1:20] $fell(bus_grant_out));
   c_read_xfer: cover property (!data_xcvr_enable_n && xcvr_dir_to_cpu);
endmodule : cbt_bus_timing
`default_nettype wire

// File: bench/cbt_far_model.sv
// far side model: wait-state peripheral, external bus master and read data source
`timescale 1ns/1ps
`default_nettype none
module cbt_far_model (
   // bench controls
   input  wire logic       core_clk,
   input  wire logic       start_wait,
   input  wire logic [3:0] wait_periods,
   input  wire logic       want_bus,
   input  wire logic [7:0] rd_val,
   // dma source
   input  wire logic       dma_req_ch0,
   input  wire logic       dma_req_ch1,
   input  wire logic       dma_req_ch2_floppy,
   input  wire logic       dma_req_ch3,
   output var  logic       dma_ack_ch0_n,
   output var  logic       dma_ack_ch1_n,
   output var  logic       dma_ack_ch2_n,
   output var  logic       dma_ack_ch3_n,
   output var  logic       transfer_count_done,
   // block side
   input  wire logic       processor_clock,
   input  wire logic       data_xcvr_enable_n,
   input  wire logic       xcvr_dir_to_cpu,
   output var  logic       wait_pull_n,
   output var  logic       ext_bus_request_n,
   output var  logic [7:0] sys_data_in
);
   logic [3:0] left_reg = 4'h0;
   logic       pclk_q   = 1'b0;
   logic [7:0] last_reg = 8'h00;
   logic [3:0] ack_n_reg = 4'hf;
   logic [1:0] xfer_cnt  = 2'h0;
   logic       tc_reg    = 1'b0;
   always @(posedge core_clk) begin
      // each channel is answered one clock after its request, on its own line
      ack_n_reg <= ~{dma_req_ch3, dma_req_ch2_floppy, dma_req_ch1, dma_req_ch0};
      xfer_cnt  <= (ack_n_reg == 4'hf) ? 2'h0 : xfer_cnt + 2'h1;
      // programmed count is four transfers; done pulses on the last one
      tc_reg    <= (ack_n_reg != 4'hf) && (xfer_cnt == 2'h2);
   end
   assign {dma_ack_ch3_n, dma_ack_ch2_n, dma_ack_ch1_n, dma_ack_ch0_n} = ack_n_reg;
   assign transfer_count_done = tc_reg;
   always @(posedge core_clk) begin
      pclk_q <= processor_clock;
      // clamp keeps the line low no longer than ten processor periods
      if (start_wait)
         left_reg <= (wait_periods > 4'ha) ? 4'ha : wait_periods;
      else if (processor_clock && !pclk_q && left_reg != 4'h0)
         left_reg <= left_reg - 4'h1;
      if (!data_xcvr_enable_n && xcvr_dir_to_cpu)
         last_reg <= rd_val;
   end
   assign wait_pull_n = (left_reg == 4'h0);
   assign ext_bus_request_n = !want_bus;
   // released data bus shows the inverse of what it last carried
   assign sys_data_in = (!data_xcvr_enable_n && xcvr_dir_to_cpu) ? rd_val : ~last_reg;
endmodule : cbt_far_model
`default_nettype wire

// File: bench/test_cbt_bus_timing.sv
// self-checking bench for the cpu bus timing control block
`timescale 1ns/1ps
`default_nettype none
module test_cbt_bus_timing;
   import cbt_pkg::*;
   logic        core_clk, sys_rst, speed_fast, raw_reset_in_n, addr_latch_strobe;
   logic        cpu_rd_n, data_phase, intack_cycle, start_wait, want_bus;
   logic        ext_bus_request_n, wait_pull_n, cpu_data_oe_n, cpu_ready, sys_data_oe_n;
   logic        sys_addr_oe_n, data_xcvr_enable_n, xcvr_dir_to_cpu, bus_grant_out;
   logic        processor_clock, bus_proc_clock, bus_osc_clock, timer_base_clock;
   logic        bus_reset_out, sys_reset_out, reset_out_n;
   logic [7:0]  cpu_ad_in, cpu_addr_mid, sys_data_in, rd_val, cpu_data_out, sys_data_out;
   logic [3:0]  cpu_addr_status, wait_periods;
   logic [19:0] sys_addr_out;
   logic        dma_req_ch0, dma_req_ch1, dma_req_ch2_floppy, dma_req_ch3;
   logic        dma_ack_ch0_n, dma_ack_ch1_n, dma_ack_ch2_n, dma_ack_ch3_n, transfer_count_done;
   int          mismatches, n_tests;
   // open collector line with pull-up: only the model ever pulls it low
   wire logic   shared_wait_line = wait_pull_n;
   cbt_bus_timing cbt_bus_timing_inst (.*);
   cbt_far_model  cbt_far_model_inst (.*);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic t_clocks(input logic fast, input int hi, input int rises);
      int   h, r, t, o, b;
      logic pq;
      {h, r, t, o, b} = '0;
      speed_fast = fast;
      tick(24);
      pq = processor_clock;
      repeat (24) begin
         tick(1);
         h += processor_clock;
         r += processor_clock & !pq;
         pq = processor_clock;
         t += timer_base_clock;
         o += bus_osc_clock;
         b += (bus_proc_clock !== processor_clock);
      end
      chk(h, hi, "cpu clock high");
      chk(r, rises, "cpu clock period");
      chk(t, 12, "timer clock high");
      chk(o, 12, "osc clock high");
      chk(b, 0, "bus clock copy");
      $display("test clocks fast=%0b done", fast);
   endtask : t_clocks
   task automatic t_addr;
      cpu_ad_in = 8'h5a;
      cpu_addr_status = 4'ha;
      cpu_addr_mid = 8'hc3;
      addr_latch_strobe = 1'b1;
      tick(1);
      addr_latch_strobe = 1'b0;
      tick(1);
      cpu_ad_in = 8'h11;
      cpu_addr_status = 4'h5;
      cpu_addr_mid = 8'h3c;
      tick(2);
      chk(sys_addr_out, 20'ha3c5a, "address");
      $display("test address done");
   endtask : t_addr
   task automatic t_xcvr;
      rd_val = 8'h69;
      cpu_rd_n = 1'b0;
      data_phase = 1'b1;
      tick(3);
      chk({cpu_data_oe_n, data_xcvr_enable_n, xcvr_dir_to_cpu, cpu_data_out}, 11'h169, "read");
      cpu_rd_n = 1'b1;
      cpu_ad_in = 8'h96;
      tick(3);
      chk({sys_data_oe_n, data_xcvr_enable_n, xcvr_dir_to_cpu, sys_data_out}, 11'h096, "write");
      intack_cycle = 1'b1;
      tick(2);
      chk(data_xcvr_enable_n, 1'b1, "intack");
      intack_cycle = 1'b0;
      data_phase = 1'b0;
      tick(2);
      chk(data_xcvr_enable_n, 1'b1, "address phase");
      $display("test transceiver done");
   endtask : t_xcvr
   task automatic t_ready(input logic [3:0] n);
      int w, lo;
      // start the wait just after the processor clock rises, so the phase is known
      for (w = 0; w < 12 && processor_clock !== 1'b0; w++)
         tick(1);
      for (w = 0; w < 12 && processor_clock !== 1'b1; w++)
         tick(1);
      wait_periods = n;
      start_wait = 1'b1;
      tick(1);
      start_wait = 1'b0;
      for (w = 0; w < 20 && cpu_ready !== 1'b0; w++)
         tick(1);
      for (lo = 0; lo < 100 && cpu_ready !== 1'b1; lo++)
         tick(1);
      chk(lo % int'(CBT_DIV_SLOW), 0, "whole periods");
      chk(lo, int'(CBT_DIV_SLOW) * (int'(n) + 1), "wait length");
      $display("test ready %0d done", n);
   endtask : t_ready
   task automatic t_rst;
      raw_reset_in_n = 1'b0;
      tick(3);
      chk({bus_reset_out, sys_reset_out, reset_out_n}, 3'b110, "reset on");
      raw_reset_in_n = 1'b1;
      tick(3);
      chk({bus_reset_out, sys_reset_out, reset_out_n}, 3'b001, "reset off");
      $display("test reset done");
   endtask : t_rst
   task automatic t_grant;
      want_bus = 1'b1;
      tick(3);
      data_phase = 1'b1;
      tick(2);
      chk({bus_grant_out, sys_addr_oe_n, data_xcvr_enable_n}, 3'b111, "granted");
      want_bus = 1'b0;
      data_phase = 1'b0;
      tick(3);
      chk({bus_grant_out, sys_addr_oe_n}, 2'b00, "released");
      $display("test grant done");
   endtask : t_grant
   task automatic t_dma;
      dma_req_ch2_floppy = 1'b1;
      tick(1);
      chk({dma_ack_ch3_n, dma_ack_ch2_n, dma_ack_ch1_n, dma_ack_ch0_n}, 4'hb, "dma ack");
      tick(3);
      chk(transfer_count_done, 1'b1, "count done");
      tick(1);
      chk(transfer_count_done, 1'b0, "count pulse");
      dma_req_ch2_floppy = 1'b0;
      tick(1);
      chk({dma_ack_ch3_n, dma_ack_ch2_n, dma_ack_ch1_n, dma_ack_ch0_n}, 4'hf, "dma idle");
      $display("test dma done");
   endtask : t_dma
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {mismatches, n_tests} = '0;
      {sys_rst, raw_reset_in_n, cpu_rd_n} = 3'b111;
      {speed_fast, addr_latch_strobe, data_phase, intack_cycle, start_wait, want_bus} = '0;
      {dma_req_ch0, dma_req_ch1, dma_req_ch2_floppy, dma_req_ch3} = '0;
      {cpu_ad_in, cpu_addr_mid, rd_val, cpu_addr_status, wait_periods} = '0;
      tick(3);
      sys_rst = 1'b0;
      tick(4);
      t_clocks(1'b0, 8, 4);
      t_clocks(1'b1, 12, 6);
      t_clocks(1'b0, 8, 4);
      t_addr;
      t_xcvr;
      t_ready(4'h1);
      t_ready(4'h2);
      t_ready(4'ha);
      t_rst;
      t_grant;
      t_dma;
      report_and_stop;
   end
   // the tests need about 300 cycles; this limit is ample
   initial begin
      #200000;
      mismatches++;
      $display("BAD t=%0t watchdog expired", $time);
      report_and_stop;
   end
endmodule : test_cbt_bus_timing
`default_nettype wire
